// file: gdsc_regs.sv
// Serial register bank of an H-bridge gate driver: status, main control, configuration.
// Assumes the serial pins and fault inputs are synchronous to clk and the serial clock
// is well below clk, so each serial edge is seen as a level change between two clk edges.
// What this block does
// - Summary top bit ORs faults except warning
// - Address zero holds seven device fault flags
// - Address one upper nibble: gate-drive faults
// - Address one lower nibble: overcurrent faults
// - Status registers read-only, reset to zero
// - Lock code blocks writes except address two
// - Unlocked, other lock values change nothing
// - Unlock code 011b; reset starts unlocked
// - Bit two ORed with bridge input one
// - Bit one ORed with bridge input two
// - Writing bit zero clears latched faults
// - Reserved bits seven, six are read-write
// - Word: rw bit, address, spare, data
// - Write frame returns previous register contents
// - Settings reset on lockout or sleep exit
`timescale 1ns/1ps
`default_nettype none
module gdsc_regs
	import gdsc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       scs_n,
	input  wire logic       sclk,
	input  wire logic       sdi,
	output logic            sdo,
	output logic            sdo_oe,
	input  wire logic       settings_reset,
	input  wire logic [6:0] device_fault_in,
	input  wire logic [7:0] fet_fault_in,
	input  wire logic       bridge_pin_one,
	input  wire logic       bridge_pin_two,
	output logic            bridge_input_one_bit,
	output logic            bridge_input_two_bit,
	output logic            fault_active,
	output logic            registers_locked,
	output logic [7:0]      drive_and_watchdog_control,
	output logic [7:0]      overcurrent_monitor_control,
	output logic [7:0]      regulation_config
);
	import gdsc_pkg::*;

	logic [1:0]  rst_sync;
	logic        rst_n;
	gdsc_state_s st_reg;
	gdsc_state_s st_next;
	logic        sclk_fall;
	logic        sclk_rise;
	logic        frame_end;
	logic [3:0]  cmd_addr;
	logic        write_ok;
	logic        clear_pulse;
	logic [4:0]  tx_index;
	logic [7:0]  summary_now;

	// Reset is released through two flops so every state flop leaves reset on one edge.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_sync <= 2'h0;
		end
		else
		begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Summary register with its OR bit on top, warning excluded.
	function automatic logic [7:0] summary_of(input logic [6:0] lat);
		summary_of = {|lat[6:1], lat};
	endfunction : summary_of

	// Register read mux; unmapped addresses read as zero.
	function automatic logic [7:0] read_reg(input gdsc_state_s s, input logic [3:0] a);
		if (a == GDSC_ADDR_FAULT_SUMMARY)
		begin
			read_reg = summary_of(s.fault_lat);
		end
		else if (a == GDSC_ADDR_PER_FET)
		begin
			read_reg = s.fet_lat;
		end
		else if (a == GDSC_ADDR_MAIN_CONTROL)
		begin
			read_reg = {s.reserved, s.lock, s.in_one, s.in_two, 1'b0};
		end
		else if (a == GDSC_ADDR_DRIVE_WD)
		begin
			read_reg = s.drive_wd;
		end
		else if (a == GDSC_ADDR_OC_MONITOR)
		begin
			read_reg = s.oc_monitor;
		end
		else if (a == GDSC_ADDR_REGULATION)
		begin
			read_reg = s.regulation;
		end
		else
		begin
			read_reg = GDSC_UNMAPPED_READ;
		end
	endfunction : read_reg

	// Edge detection; pins are synchronous so they are compared directly.
	assign sclk_fall = st_reg.sclk_prev & ~sclk & (st_reg.frame == GDSC_FR_ACTIVE);
	assign sclk_rise = ~st_reg.sclk_prev & sclk & (st_reg.frame == GDSC_FR_ACTIVE);
	assign frame_end = scs_n & (st_reg.frame == GDSC_FR_ACTIVE);
	assign cmd_addr  = st_reg.rx_shift[GDSC_ADDR_HI:GDSC_ADDR_LO];
	assign tx_index  = GDSC_DATA_TOP - st_reg.bit_cnt;

	// A write is taken only on exactly sixteen bits; short or long frames are dropped.
	// Status addresses and out-of-map addresses never take a write, and the lock
	// admits only the main control address.
	always_comb
	begin
		write_ok = frame_end && (st_reg.bit_cnt == GDSC_CNT_FULL)
			&& !st_reg.rx_shift[GDSC_RW_BIT];
		if (cmd_addr == GDSC_ADDR_FAULT_SUMMARY || cmd_addr == GDSC_ADDR_PER_FET)
		begin
			write_ok = 1'b0;
		end
		else if (cmd_addr > GDSC_ADDR_REGULATION)
		begin
			write_ok = 1'b0;
		end
		else if (st_reg.lock == GDSC_LOCK_CODE && cmd_addr != GDSC_ADDR_MAIN_CONTROL)
		begin
			write_ok = 1'b0;
		end
		clear_pulse = write_ok && (cmd_addr == GDSC_ADDR_MAIN_CONTROL)
			&& st_reg.rx_shift[GDSC_CLR_BIT];
	end

	// Next-state logic for the serial engine, the latches and the settings.
	always_comb
	begin
		st_next = st_reg;
		st_next.sclk_prev = sclk;

		// Frame start and end follow the chip select.
		case (st_reg.frame)
			GDSC_FR_IDLE:
			begin
				if (!scs_n)
				begin
					st_next.frame = GDSC_FR_ACTIVE;
					st_next.bit_cnt = 5'h00;
					st_next.sdo = 1'b0;
					st_next.tx_byte = GDSC_UNMAPPED_READ;
				end
			end
			GDSC_FR_ACTIVE:
			begin
				if (scs_n)
				begin
					st_next.frame = GDSC_FR_IDLE;
					st_next.sdo = 1'b0;
				end
			end
			default:
			begin
				st_next.frame = GDSC_FR_IDLE;
			end
		endcase

		// Capture on falling edges, MSB first; the count saturates so long frames fail.
		if (sclk_fall)
		begin
			st_next.rx_shift = {st_reg.rx_shift[14:0], sdi};
			if (st_reg.bit_cnt != GDSC_CNT_MAX)
			begin
				st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
			end
			// After the command bits the addressed contents are frozen for the reply,
			// so a write frame answers with the value held before the write.
			if (st_reg.bit_cnt + 5'h01 == GDSC_CNT_CMD)
			begin
				st_next.tx_byte = read_reg(st_reg, {st_reg.rx_shift[2:0], sdi});
			end
		end

		// Drive on rising edges; the upper byte of the reply is zero.
		if (sclk_rise)
		begin
			if (st_reg.bit_cnt >= GDSC_CNT_DATA && st_reg.bit_cnt < GDSC_CNT_FULL)
			begin
				st_next.sdo = st_reg.tx_byte[tx_index[2:0]];
			end
			else
			begin
				st_next.sdo = 1'b0;
			end
		end

		// Committed writes.
		if (write_ok)
		begin
			if (cmd_addr == GDSC_ADDR_MAIN_CONTROL)
			begin
				st_next.reserved = st_reg.rx_shift[GDSC_RSVD_HI:GDSC_RSVD_LO];
				st_next.in_one = st_reg.rx_shift[GDSC_IN1_BIT];
				st_next.in_two = st_reg.rx_shift[GDSC_IN2_BIT];
				if (st_reg.lock != GDSC_LOCK_CODE
					&& st_reg.rx_shift[GDSC_LOCK_HI:GDSC_LOCK_LO] == GDSC_LOCK_CODE)
				begin
					st_next.lock = GDSC_LOCK_CODE;
				end
				else if (st_reg.lock == GDSC_LOCK_CODE
					&& st_reg.rx_shift[GDSC_LOCK_HI:GDSC_LOCK_LO] == GDSC_UNLOCK_CODE)
				begin
					st_next.lock = GDSC_UNLOCK_CODE;
				end
			end
			else if (cmd_addr == GDSC_ADDR_DRIVE_WD)
			begin
				st_next.drive_wd = st_reg.rx_shift[7:0];
			end
			else if (cmd_addr == GDSC_ADDR_OC_MONITOR)
			begin
				st_next.oc_monitor = st_reg.rx_shift[7:0];
			end
			else if (cmd_addr == GDSC_ADDR_REGULATION)
			begin
				st_next.regulation = st_reg.rx_shift[7:0];
			end
		end

		// Settings return to reset on lockout or sleep exit; this wins over a write.
		if (settings_reset)
		begin
			st_next.reserved = GDSC_RSVD_RESET;
			st_next.lock = GDSC_UNLOCK_CODE;
			st_next.in_one = 1'b0;
			st_next.in_two = 1'b0;
			st_next.drive_wd = GDSC_DRIVE_WD_RESET;
			st_next.oc_monitor = GDSC_OC_MONITOR_RESET;
			st_next.regulation = GDSC_REGULATION_RESET;
		end

		// Faults latch; a fault present in the clearing cycle stays set.
		if (clear_pulse || settings_reset)
		begin
			st_next.fault_lat = device_fault_in;
			st_next.fet_lat = fet_fault_in;
		end
		else
		begin
			st_next.fault_lat = st_reg.fault_lat | device_fault_in;
			st_next.fet_lat = st_reg.fet_lat | fet_fault_in;
		end
	end

	// State register; all flops reset to their defined start values.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '{
				frame:      GDSC_FR_IDLE,
				sclk_prev:  1'b0,
				bit_cnt:    5'h00,
				rx_shift:   16'h0000,
				tx_byte:    GDSC_UNMAPPED_READ,
				sdo:        1'b0,
				fault_lat:  GDSC_STATUS_RESET[6:0],
				fet_lat:    GDSC_STATUS_RESET,
				reserved:   GDSC_RSVD_RESET,
				lock:       GDSC_UNLOCK_CODE,
				in_one:     1'b0,
				in_two:     1'b0,
				drive_wd:   GDSC_DRIVE_WD_RESET,
				oc_monitor: GDSC_OC_MONITOR_RESET,
				regulation: GDSC_REGULATION_RESET
			};
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Outputs; the serial output floats outside a frame, so its enable follows select.
	assign sdo    = st_reg.sdo;
	assign sdo_oe = ~scs_n;
	assign bridge_input_one_bit = bridge_pin_one | st_reg.in_one;
	assign bridge_input_two_bit = bridge_pin_two | st_reg.in_two;
	assign summary_now  = summary_of(st_reg.fault_lat);
	assign fault_active = summary_now[GDSC_SUM_BIT];
	assign registers_locked = (st_reg.lock == GDSC_LOCK_CODE);
	assign drive_and_watchdog_control  = st_reg.drive_wd;
	assign overcurrent_monitor_control = st_reg.oc_monitor;
	assign regulation_config           = st_reg.regulation;
endmodule : gdsc_regs
`default_nettype wire

// file: gdsc_pkg.sv
// Constants, types and register layout of the gate driver register bank.
// Assumes nothing beyond a SystemVerilog compiler; used by gdsc_regs.
`default_nettype none
package gdsc_pkg;
	// Register addresses of the serial map.
	localparam logic [3:0] GDSC_ADDR_FAULT_SUMMARY = 4'h0;
	localparam logic [3:0] GDSC_ADDR_PER_FET       = 4'h1;
	localparam logic [3:0] GDSC_ADDR_MAIN_CONTROL  = 4'h2;
	localparam logic [3:0] GDSC_ADDR_DRIVE_WD      = 4'h3;
	localparam logic [3:0] GDSC_ADDR_OC_MONITOR    = 4'h4;
	localparam logic [3:0] GDSC_ADDR_REGULATION    = 4'h5;

	// Serial command word layout.
	localparam int GDSC_FRAME_BITS = 16;
	localparam int GDSC_RW_BIT     = 15;
	localparam int GDSC_ADDR_HI    = 14;
	localparam int GDSC_ADDR_LO    = 11;
	localparam int GDSC_CMD_BITS   = 5;
	localparam int GDSC_DATA_START = 8;
	localparam logic [4:0] GDSC_CNT_FULL = 5'h10;
	localparam logic [4:0] GDSC_CNT_MAX  = 5'h1f;
	localparam logic [4:0] GDSC_CNT_CMD  = 5'h05;
	localparam logic [4:0] GDSC_CNT_DATA = 5'h08;
	localparam logic [4:0] GDSC_DATA_TOP = 5'h0f;

	// Main control field positions.
	localparam int GDSC_RSVD_HI  = 7;
	localparam int GDSC_RSVD_LO  = 6;
	localparam int GDSC_LOCK_HI  = 5;
	localparam int GDSC_LOCK_LO  = 3;
	localparam int GDSC_IN1_BIT  = 2;
	localparam int GDSC_IN2_BIT  = 1;
	localparam int GDSC_CLR_BIT  = 0;

	// Fault summary positions: top bit is the OR, bit 0 the warning.
	localparam int GDSC_SUM_BIT  = 7;
	localparam int GDSC_WARN_BIT = 0;

	// Lock codes and reset values.
	localparam logic [2:0] GDSC_LOCK_CODE   = 3'h6;
	localparam logic [2:0] GDSC_UNLOCK_CODE = 3'h3;
	localparam logic [1:0] GDSC_RSVD_RESET  = 2'h0;
	localparam logic [7:0] GDSC_STATUS_RESET     = 8'h00;
	localparam logic [7:0] GDSC_DRIVE_WD_RESET   = 8'h07;
	localparam logic [7:0] GDSC_OC_MONITOR_RESET = 8'h70;
	localparam logic [7:0] GDSC_REGULATION_RESET = 8'h00;
	localparam logic [7:0] GDSC_UNMAPPED_READ    = 8'h00;

	// Frame tracking state.
	typedef enum logic {
		GDSC_FR_IDLE   = 1'b0,
		GDSC_FR_ACTIVE = 1'b1
	} gdsc_frame_e;

	// Whole state of the register bank.
	typedef struct packed {
		gdsc_frame_e frame;
		logic        sclk_prev;
		logic [4:0]  bit_cnt;
		logic [15:0] rx_shift;
		logic [7:0]  tx_byte;
		logic        sdo;
		logic [6:0]  fault_lat;
		logic [7:0]  fet_lat;
		logic [1:0]  reserved;
		logic [2:0]  lock;
		logic        in_one;
		logic        in_two;
		logic [7:0]  drive_wd;
		logic [7:0]  oc_monitor;
		logic [7:0]  regulation;
	} gdsc_state_s;
endpackage : gdsc_pkg
`default_nettype wire

// file: gdsc_host.sv
// Host serial master model for the gate driver register bank.
// Assumes the bench calls xfer hierarchically and clk is the bench clock.
`timescale 1ns/1ps
`default_nettype none
module gdsc_host (
	input  wire logic clk,
	output logic      scs_n,
	output logic      sclk,
	output logic      sdi,
	input  wire logic sdo
);
	// Deselected with the clock low, so the first frame starts clean.
	initial
	begin
		scs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// One frame of nb bits, MSB first, four clk per serial phase and one hold clock after each fall.
	task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
		r = 16'h0000;
		@(negedge clk) scs_n <= 1'b0;
		for (int i = 0; i < nb; i++)
		begin
			sdi <= w[15-i];
			repeat (4) @(negedge clk);
			sclk <= 1'b1;
			repeat (4) @(negedge clk);
			sclk <= 1'b0;
			r = {r[14:0], sdo};
			// Data holds one more clock, so the falling edge is taken with this bit.
			@(negedge clk);
		end
		repeat (4) @(negedge clk);
		scs_n <= 1'b1;
		sdi <= ~sdi; // A released line never keeps its last bit.
		// Twenty clocks keep the deselect gap above half a microsecond.
		repeat (20) @(negedge clk);
	endtask : xfer
endmodule : gdsc_host
`default_nettype wire

// file: gdsc_regs_assertions.sv
// Port assertions for the gate driver register bank.
// Assumes one clock domain; bound to gdsc_regs from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module gdsc_regs_chk (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       scs_n,
	input wire logic       sdo_oe,
	input wire logic       settings_reset,
	input wire logic [6:0] device_fault_in,
	input wire logic       bridge_pin_one,
	input wire logic       bridge_pin_two,
	input wire logic       bridge_input_one_bit,
	input wire logic       bridge_input_two_bit,
	input wire logic       fault_active,
	input wire logic       registers_locked,
	input wire logic [7:0] drive_and_watchdog_control,
	input wire logic [7:0] overcurrent_monitor_control,
	input wire logic [7:0] regulation_config
);
	import gdsc_pkg::*;
	// All checks share the bank clock and its reset.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// A pin is never masked by its register bit.
	pin_one_or_a: assert property (bridge_pin_one |-> bridge_input_one_bit)
		else $error("input one lost its pin");
	pin_two_or_a: assert property (bridge_pin_two |-> bridge_input_two_bit)
		else $error("input two lost its pin");
	sdo_enable_a: assert property (sdo_oe == !scs_n)
		else $error("sdo enable wrong");
	// The internal reset lasts two edges past release, hence the depth of three.
	fault_set_a: assert property ($past(resetn, 3) && |device_fault_in[6:1] |=> fault_active)
		else $error("summary missed a fault");
	fault_hold_a: assert property (fault_active && !settings_reset && !$rose(scs_n) |=> fault_active)
		else $error("summary dropped by itself");
	lock_frame_a: assert property (!scs_n && !settings_reset |=> $stable(registers_locked))
		else $error("lock changed inside a frame");
	locked_cfg_a: assert property (registers_locked && !settings_reset |=>
		$stable(drive_and_watchdog_control) && $stable(overcurrent_monitor_control)
		&& $stable(regulation_config))
		else $error("locked setting changed");
	settings_back_a: assert property (settings_reset |=> !registers_locked
		&& drive_and_watchdog_control == GDSC_DRIVE_WD_RESET
		&& overcurrent_monitor_control == GDSC_OC_MONITOR_RESET
		&& regulation_config == GDSC_REGULATION_RESET)
		else $error("settings not restored");
	// Main scenarios reached.
	cover property ($rose(registers_locked));
	cover property ($fell(fault_active));
	cover property (settings_reset);
endmodule : gdsc_regs_chk
`default_nettype wire

// file: gdsc_regs_tb.sv
// Self-checking bench for the gate driver register bank.
// Assumes gdsc_pkg, gdsc_regs, gdsc_host and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module gdsc_regs_tb;
	import gdsc_pkg::*;
	localparam logic [7:0] RST_TAB [7] = '{8'h00, 8'h00, 8'h18, 8'h07, 8'h70, 8'h00, 8'h00};
	logic        clk;
	logic        resetn;
	logic        scs_n;
	logic        sclk;
	logic        sdi;
	logic        sdo;
	logic        sdo_oe;
	logic        settings_reset;
	logic [6:0]  device_fault_in;
	logic [7:0]  fet_fault_in;
	logic        bridge_pin_one;
	logic        bridge_pin_two;
	logic        bridge_input_one_bit;
	logic        bridge_input_two_bit;
	logic        fault_active;
	logic        registers_locked;
	logic [7:0]  drive_and_watchdog_control;
	logic [7:0]  overcurrent_monitor_control;
	logic [7:0]  regulation_config;
	logic [15:0] rsp;
	int          err_total;
	int          n_compared;
	gdsc_regs i_gdsc_regs (.clk, .resetn, .scs_n, .sclk, .sdi, .sdo, .sdo_oe, .settings_reset,
		.device_fault_in, .fet_fault_in, .bridge_pin_one, .bridge_pin_two, .bridge_input_one_bit,
		.bridge_input_two_bit, .fault_active, .registers_locked, .drive_and_watchdog_control,
		.overcurrent_monitor_control, .regulation_config);
	gdsc_host i_gdsc_host (.clk, .scs_n, .sclk, .sdi, .sdo);
	// Free-running 40 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_gdsc_host.xfer({1'b0, a, 3'h0, d}, 16, rsp);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		i_gdsc_host.xfer({1'b1, a, 3'h0, 8'h00}, 16, rsp);
		check(rsp[7:0], exp);
	endtask : rd
	task automatic complete_run;
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// A hang is cut short and counted as a failure.
	initial
	begin
		#2ms;
		err_total++;
		$display("mismatch at %0t: run did not finish", $time);
		complete_run();
	end
	// Main sequence: reset map, writes, faults, lock, framing, settings reset.
	initial
	begin
		logic [7:0] e;
		{resetn, settings_reset, bridge_pin_one, bridge_pin_two} = 4'h0;
		device_fault_in = 7'h00;
		fet_fault_in = 8'h00;
		err_total = 0;
		n_compared = 0;
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		for (int a = 0; a < 7; a++) rd(a[3:0], RST_TAB[a]);
		wr(4'h3, 8'ha5);
		check(rsp[7:0], 8'h07);
		rd(4'h3, 8'ha5);
		wr(4'h0, 8'hff);
		rd(4'h0, 8'h00);
		wr(4'h1, 8'hff);
		rd(4'h1, 8'h00);
		// Each fault bit is pulsed, must stay latched, then is cleared.
		for (int b = 0; b < 8; b++)
		begin
			e = 8'h01 << b;
			device_fault_in = e[6:0];
			fet_fault_in = e;
			@(negedge clk);
			{device_fault_in, fet_fault_in} = 15'h0000;
			rd(4'h1, e);
			if (b == 7) e = 8'h00;
			else if (b != 0) e[7] = 1'b1;
			rd(4'h0, e);
			wr(4'h2, 8'h19);
			check(rsp[7:0], 8'h18);
			rd(4'h0, 8'h00);
			rd(4'h1, 8'h00);
		end
		wr(4'h2, 8'hc6);
		rd(4'h2, 8'hde);
		check({6'h0, bridge_input_one_bit, bridge_input_two_bit}, 8'h03);
		wr(4'h2, 8'h30);
		{bridge_pin_one, bridge_pin_two} = 2'h3;
		@(negedge clk);
		check({5'h0, bridge_input_one_bit, bridge_input_two_bit, registers_locked}, 8'h07);
		wr(4'h3, 8'h11);
		rd(4'h3, 8'ha5);
		wr(4'h2, 8'h28);
		rd(4'h2, 8'h30);
		wr(4'h2, 8'h18);
		wr(4'h3, 8'h11);
		rd(4'h3, 8'h11);
		i_gdsc_host.xfer(16'h1822, 15, rsp);
		rd(4'h3, 8'h11);
		wr(4'h4, 8'h0f);
		wr(4'h5, 8'h3c);
		wr(4'h2, 8'h30);
		@(negedge clk) settings_reset = 1'b1;
		@(negedge clk) settings_reset = 1'b0;
		for (int a = 2; a < 6; a++) rd(a[3:0], RST_TAB[a]);
		complete_run();
	end
endmodule : gdsc_regs_tb
bind gdsc_regs gdsc_regs_chk i_gdsc_regs_chk (.clk, .resetn, .scs_n, .sdo_oe, .settings_reset,
	.device_fault_in, .bridge_pin_one, .bridge_pin_two, .bridge_input_one_bit,
	.bridge_input_two_bit, .fault_active, .registers_locked, .drive_and_watchdog_control,
	.overcurrent_monitor_control, .regulation_config);
`default_nettype wire
